// File: asf_params.svh
// Offsets, field positions and reset values of the cipher status block.
// Assumes an 8-bit register space with 12-bit byte addresses.
`ifndef ASF_PARAMS_SVH
`define ASF_PARAMS_SVH
`define ASF_ADDR_W 12
`define ASF_OFF_LOAD 12'hFB8
`define ASF_OFF_KEY 12'hFB9
`define ASF_OFF_CTRL 12'hFBA
`define ASF_OFF_STAT 12'hFBB
`define ASF_OFF_IRQ_STAT 12'hFBC
`define ASF_OFF_IRQ_MASK 12'hFBD
`define ASF_STAT_BUSY 7
`define ASF_STAT_ERR 3
`define ASF_STAT_VEC 2
`define ASF_STAT_KEY 1
`define ASF_STAT_BLK 0
`define ASF_STAT_RST 8'h00
`define ASF_CTRL_RST 7'h00
`define ASF_IRQ_ERR 0
`define ASF_IRQ_DONE 1
`define ASF_IRQ_W 2
`define ASF_IRQ_RST 2'h0
`define ASF_BLOCK_BYTES 16
`define ASF_CNT_W 5
`define ASF_IDX_W 4
`endif

// File: asf_pkg.sv
// Types shared by the cipher status block and its datapath.
// Assumes asf_params.svh defines the field widths.
`include "asf_params.svh"
package asf_pkg;
  typedef enum logic [1:0] {
    ASF_IDLE = 2'b01,
    ASF_BUSY = 2'b10
  } asf_state_t;
  // Control register less its reserved bit 6
  typedef struct packed {
    logic autodis;
    logic irq_sel;
    logic [1:0] mode;
    logic iv_en;
    logic decrypt;
    logic accel_on;
  } asf_ctrl_t;
  // One accepted load byte toward the datapath
  typedef struct packed {
    logic key_wr;
    logic vec_wr;
    logic blk_wr;
    logic [`ASF_IDX_W-1:0] idx;
    logic [7:0] byte_v;
  } asf_load_t;
endpackage : asf_pkg

// File: asf_status_flags.sv
// Cipher accelerator status, start/busy handshake and load tracking.
// Assumes a single-cycle register port and a datapath giving done/error pulses.
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/100ps
`include "asf_params.svh"
module asf_status_flags #(
  parameter int BYTES = `ASF_BLOCK_BYTES
) (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic [`ASF_ADDR_W-1:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_done,
  input wire logic i_proc_err,
  output logic [7:0] o_rdata,
  output logic o_irq,
  output logic o_start,
  output asf_pkg::asf_ctrl_t o_ctrl,
  output asf_pkg::asf_load_t o_load
);
  localparam logic [`ASF_CNT_W-1:0] FULL = `ASF_CNT_W'(BYTES);

  // Next count after an accepted byte; a full load restarts
  function automatic logic [`ASF_CNT_W-1:0] cnt_next(input logic [`ASF_CNT_W-1:0] c);
    cnt_next = (c == FULL) ? `ASF_CNT_W'(1) : c + `ASF_CNT_W'(1);
  endfunction : cnt_next

  asf_pkg::asf_state_t state_q, state_d;
  asf_pkg::asf_ctrl_t ctrl_q, ctrl_d;
  asf_pkg::asf_load_t load_q, load_d;
  logic [`ASF_CNT_W-1:0] key_cnt_q, key_cnt_d;
  logic [`ASF_CNT_W-1:0] vec_cnt_q, vec_cnt_d;
  logic [`ASF_CNT_W-1:0] blk_cnt_q, blk_cnt_d;
  logic err_q, err_d;
  logic start_q, start_d;
  logic [`ASF_IRQ_W-1:0] irq_st_q, irq_st_d;
  logic [`ASF_IRQ_W-1:0] irq_mask_q, irq_mask_d;
  logic irq_q, irq_d;
  logic [7:0] rdata_q, rdata_d;
  logic busy, on, key_ld, vec_ld, blk_ld;
  logic wr_key, wr_load, wr_ctrl, wr_stat, wr_mask, rd_irq;
  logic key_ok, vec_ok, blk_ok, err_set, ev_done;
  logic [7:0] stat;

  assign busy = (state_q == asf_pkg::ASF_BUSY);
  assign on = ctrl_q.accel_on;
  assign key_ld = (key_cnt_q == FULL);
  assign vec_ld = (vec_cnt_q == FULL);
  assign blk_ld = (blk_cnt_q == FULL);
  assign wr_key = i_wr && (i_addr == `ASF_OFF_KEY);
  assign wr_load = i_wr && (i_addr == `ASF_OFF_LOAD);
  assign wr_ctrl = i_wr && (i_addr == `ASF_OFF_CTRL);
  assign wr_stat = i_wr && (i_addr == `ASF_OFF_STAT);
  assign wr_mask = i_wr && (i_addr == `ASF_OFF_IRQ_MASK);
  assign rd_irq = i_rd && (i_addr == `ASF_OFF_IRQ_STAT);

  // Status byte as read
  always_comb begin
    stat = `ASF_STAT_RST;
    stat[`ASF_STAT_BUSY] = busy;
    stat[`ASF_STAT_ERR] = err_q;
    stat[`ASF_STAT_VEC] = vec_ld;
    stat[`ASF_STAT_KEY] = key_ld;
    stat[`ASF_STAT_BLK] = blk_ld;
  end

  // Sequencing, load counters and error flag
  always_comb begin
    state_d = state_q;
    ctrl_d = ctrl_q;
    load_d = '0;
    key_cnt_d = key_cnt_q;
    vec_cnt_d = vec_cnt_q;
    blk_cnt_d = blk_cnt_q;
    err_d = err_q;
    start_d = 1'b0;
    key_ok = wr_key && on && !busy;
    vec_ok = wr_load && on && !busy && ctrl_q.iv_en;
    blk_ok = wr_load && on && !busy && !ctrl_q.iv_en;
    err_set = on && ((busy && (wr_key || wr_load)) || (busy && i_proc_err));
    ev_done = busy && i_done && on;
    if (wr_ctrl) begin
      ctrl_d = {i_wdata[7], i_wdata[5:0]};
    end
    if (key_ok) begin
      key_cnt_d = cnt_next(key_cnt_q);
    end
    if (vec_ok) begin
      vec_cnt_d = cnt_next(vec_cnt_q);
    end
    if (blk_ok) begin
      blk_cnt_d = cnt_next(blk_cnt_q);
    end
    if (key_ok || vec_ok || blk_ok) begin
      load_d.key_wr = key_ok;
      load_d.vec_wr = vec_ok;
      load_d.blk_wr = blk_ok;
      load_d.byte_v = i_wdata;
      if (key_ok) begin
        load_d.idx = key_cnt_d[`ASF_IDX_W-1:0] - `ASF_IDX_W'(1);
      end else if (vec_ok) begin
        load_d.idx = vec_cnt_d[`ASF_IDX_W-1:0] - `ASF_IDX_W'(1);
      end else begin
        load_d.idx = blk_cnt_d[`ASF_IDX_W-1:0] - `ASF_IDX_W'(1);
      end
    end
    case (state_q)
      asf_pkg::ASF_IDLE: begin
        if (wr_stat && i_wdata[`ASF_STAT_BUSY] && on) begin
          state_d = asf_pkg::ASF_BUSY;
          start_d = 1'b1;
          err_d = 1'b0;
        end
      end
      asf_pkg::ASF_BUSY: begin
        if (i_done) begin
          state_d = asf_pkg::ASF_IDLE;
          blk_cnt_d = '0;
        end
      end
      default: begin
        state_d = asf_pkg::ASF_IDLE;
      end
    endcase
    if (err_set) begin
      err_d = 1'b1;
    end
    if (!on) begin
      state_d = asf_pkg::ASF_IDLE;
      key_cnt_d = '0;
      vec_cnt_d = '0;
      blk_cnt_d = '0;
      err_d = 1'b0;
      start_d = 1'b0;
      load_d = '0;
    end
  end

  // Interrupt status, mask and read port
  always_comb begin
    irq_st_d = rd_irq ? `ASF_IRQ_RST : irq_st_q;
    if (err_set) begin
      irq_st_d[`ASF_IRQ_ERR] = 1'b1;
    end
    if (ev_done && ctrl_q.irq_sel) begin
      irq_st_d[`ASF_IRQ_DONE] = 1'b1;
    end
    irq_mask_d = wr_mask ? i_wdata[`ASF_IRQ_W-1:0] : irq_mask_q;
    irq_d = |(irq_st_d & irq_mask_d);
    rdata_d = 8'h00;
    if (i_rd) begin
      case (i_addr)
        `ASF_OFF_CTRL: rdata_d = {ctrl_q.autodis, 1'b0, ctrl_q[5:0]};
        `ASF_OFF_STAT: rdata_d = stat;
        `ASF_OFF_IRQ_STAT: rdata_d = {{(8-`ASF_IRQ_W){1'b0}}, irq_st_q};
        `ASF_OFF_IRQ_MASK: rdata_d = {{(8-`ASF_IRQ_W){1'b0}}, irq_mask_q};
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      state_q <= asf_pkg::ASF_IDLE;
      ctrl_q <= `ASF_CTRL_RST;
      load_q <= '0;
      key_cnt_q <= '0;
      vec_cnt_q <= '0;
      blk_cnt_q <= '0;
      err_q <= 1'b0;
      start_q <= 1'b0;
      irq_st_q <= `ASF_IRQ_RST;
      irq_mask_q <= `ASF_IRQ_RST;
      irq_q <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      state_q <= state_d;
      ctrl_q <= ctrl_d;
      load_q <= load_d;
      key_cnt_q <= key_cnt_d;
      vec_cnt_q <= vec_cnt_d;
      blk_cnt_q <= blk_cnt_d;
      err_q <= err_d;
      start_q <= start_d;
      irq_st_q <= irq_st_d;
      irq_mask_q <= irq_mask_d;
      irq_q <= irq_d;
      rdata_q <= rdata_d;
    end
  end

  assign o_rdata = rdata_q;
  assign o_irq = irq_q;
  assign o_start = start_q;
  assign o_ctrl = ctrl_q;
  assign o_load = load_q;

  // Checks
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_sys_rst);

  sequence s_start_req;
    wr_stat && i_wdata[`ASF_STAT_BUSY] && on && !busy;
  endsequence

  sequence s_done_ev;
    busy && i_done && on;
  endsequence

  sequence s_stat_read;
    i_rd && i_addr == `ASF_OFF_STAT;
  endsequence

  sequence s_load_busy;
    busy && on && (wr_key || wr_load) && !i_done;
  endsequence

  start_launch_a: assert property (s_start_req |=> busy && o_start)
    else $error("start write did not launch");
  busy_fall_a: assert property (busy && i_done && on |=> !busy && !o_start)
    else $error("busy did not clear on done");
  busy_read_a: assert property (i_rd && i_addr == `ASF_OFF_STAT |=> o_rdata[`ASF_STAT_BUSY] == $past(busy))
    else $error("busy bit misread");
  err_read_a: assert property (i_rd && i_addr == `ASF_OFF_STAT |=> o_rdata[`ASF_STAT_ERR] == $past(err_q))
    else $error("error bit misread");
  key_full_a: assert property (wr_key && on && !busy && key_cnt_q == FULL - 1 |=> key_ld)
    else $error("key flag not set");
  vec_full_a: assert property (vec_ok && vec_cnt_q == FULL - 1 |=> vec_ld)
    else $error("vector flag not set");
  blk_full_a: assert property (blk_ok && blk_cnt_q == FULL - 1 |=> blk_ld)
    else $error("block flag not set");
  busy_write_a: assert property (busy && on && wr_key |=> err_q && $stable(key_cnt_q))
    else $error("write while busy not flagged");
  off_clear_a: assert property (!on |=> key_cnt_q == 0 && vec_cnt_q == 0 && !err_q && !busy)
    else $error("status not reset while off");
  done_irq_a: assert property (ev_done && ctrl_q.irq_sel && !rd_irq |=> irq_st_q[`ASF_IRQ_DONE])
    else $error("done event lost");
  done_quiet_a: assert property (!ctrl_q.irq_sel && !irq_st_q[`ASF_IRQ_DONE] |=> !irq_st_q[`ASF_IRQ_DONE])
    else $error("done raised with select off");
  zero_write_a: assert property (wr_stat && !i_wdata[`ASF_STAT_BUSY] && !busy |=> !busy && !o_start)
    else $error("zero write started operation");

  // Read path of the status byte
  rsvd_read_a: assert property (s_stat_read |=> o_rdata[6:4] == 3'h0)
    else $error("reserved status bits not zero");
  vec_read_a: assert property (s_stat_read |=> o_rdata[`ASF_STAT_VEC] == $past(vec_ld))
    else $error("vector flag misread");
  key_read_a: assert property (s_stat_read |=> o_rdata[`ASF_STAT_KEY] == $past(key_ld))
    else $error("key flag misread");
  blk_read_a: assert property (s_stat_read |=> o_rdata[`ASF_STAT_BLK] == $past(blk_ld))
    else $error("block flag misread");

  // Busy sequencing and start pulse
  busy_hold_a: assert property (busy && !i_done && on |=> busy)
    else $error("busy dropped before done");
  start_once_a: assert property (o_start |=> !o_start)
    else $error("start pulse longer than one cycle");
  busy_restart_a: assert property (busy && wr_stat |=> !o_start)
    else $error("start accepted while busy");
  done_block_a: assert property (s_done_ev |=> !blk_ld)
    else $error("block flag kept after done");
  start_err_a: assert property (s_start_req |=> !err_q)
    else $error("error flag kept over new start");
  err_keep_a: assert property (err_q && on && busy |=> err_q)
    else $error("error flag lost while busy");

  // Loads while busy and count wrap
  load_drop_a: assert property (s_load_busy |=> err_q && $stable(vec_cnt_q) && $stable(blk_cnt_q))
    else $error("load write while busy not dropped");
  busy_load_a: assert property (busy && (wr_key || wr_load) |=> o_load == '0)
    else $error("load byte passed while busy");
  key_wrap_a: assert property (key_ok && key_ld |=> key_cnt_q == 1)
    else $error("key count did not restart");
  blk_wrap_a: assert property (blk_ok && blk_ld |=> blk_cnt_q == 1)
    else $error("block count did not restart");

  // Interrupt status and level
  err_irq_a: assert property (err_set |=> irq_st_q[`ASF_IRQ_ERR])
    else $error("error event lost");
  irq_level_a: assert property (o_irq == |(irq_st_q & irq_mask_q))
    else $error("interrupt level wrong");
  irq_clear_a: assert property (rd_irq && !err_set && !ev_done |=> irq_st_q == '0)
    else $error("status read did not clear");

  // Accelerator off
  off_start_a: assert property (!on |=> !busy && !o_start && o_load == '0)
    else $error("activity while accelerator off");
endmodule : asf_status_flags

// File: asf_status_flags_bench.sv
// Self-checking bench for the cipher status block.
// Assumes asf_pkg and asf_params.svh are compiled first.
`timescale 1ns/100ps
`include "asf_params.svh"
module asf_status_flags_bench;
  logic i_sys_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic [11:0] i_addr = 12'h000;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_done = 1'b0;
  logic i_proc_err = 1'b0;
  logic [7:0] o_rdata;
  logic o_irq;
  logic o_start;
  asf_pkg::asf_ctrl_t o_ctrl;
  asf_pkg::asf_load_t o_load;
  int fail_count = 0;
  int n_tests = 0;

  asf_status_flags #(.BYTES(16)) dut_u (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_done(i_done), .i_proc_err(i_proc_err),
    .o_rdata(o_rdata), .o_irq(o_irq), .o_start(o_start), .o_ctrl(o_ctrl), .o_load(o_load));

  initial begin
    forever #2 i_sys_clk = ~i_sys_clk;
  end

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask : wr

  task automatic rchk(input logic [11:0] a, input logic [7:0] e, input string n);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1;
    chk(n, e, o_rdata);
  endtask : rchk

  task automatic loadn(input logic [11:0] a, input int n);
    for (int k = 0; k < n; k++) begin
      wr(a, 8'h3C);
    end
  endtask : loadn

  // One-cycle datapath event: done when e is 1, error otherwise
  task automatic pulse(input bit e);
    @(posedge i_sys_clk);
    if (e) i_done <= 1'b1;
    else i_proc_err <= 1'b1;
    @(posedge i_sys_clk);
    i_done <= 1'b0;
    i_proc_err <= 1'b0;
  endtask : pulse

  task automatic t_reset;
    rchk(`ASF_OFF_STAT, 8'h00, "status reset");
    chk("ctrl reset", 8'h00, {1'b0, o_ctrl});
    $display("t_reset done");
  endtask : t_reset

  task automatic t_load;
    wr(`ASF_OFF_CTRL, 8'h01);
    loadn(`ASF_OFF_KEY, 15);
    rchk(`ASF_OFF_STAT, 8'h00, "key 15 bytes");
    wr(`ASF_OFF_KEY, 8'hA5);
    #1;
    chk("last key idx", 8'h0F, {4'h0, o_load.idx});
    chk("last key byte", 8'hA5, o_load.byte_v);
    rchk(`ASF_OFF_STAT, 8'h02, "key loaded");
    wr(`ASF_OFF_CTRL, 8'h05);
    loadn(`ASF_OFF_LOAD, 16);
    rchk(`ASF_OFF_STAT, 8'h06, "vector loaded");
    wr(`ASF_OFF_CTRL, 8'h21);
    loadn(`ASF_OFF_LOAD, 16);
    rchk(`ASF_OFF_STAT, 8'h07, "block loaded");
    rchk(`ASF_OFF_CTRL, 8'h21, "ctrl readback");
    $display("t_load done");
  endtask : t_load

  task automatic t_run;
    wr(`ASF_OFF_IRQ_MASK, 8'h03);
    rchk(`ASF_OFF_IRQ_MASK, 8'h03, "irq mask");
    wr(`ASF_OFF_STAT, 8'h00);
    rchk(`ASF_OFF_STAT, 8'h07, "zero start");
    wr(`ASF_OFF_STAT, 8'h80);
    #1;
    chk("start pulse", 8'h01, {7'h00, o_start});
    rchk(`ASF_OFF_STAT, 8'h87, "busy");
    wr(`ASF_OFF_KEY, 8'h11);
    #1;
    chk("busy key write", 8'h00, {7'h00, o_load.key_wr});
    rchk(`ASF_OFF_STAT, 8'h8F, "busy error");
    wr(`ASF_OFF_LOAD, 8'h22);
    #1;
    chk("busy block write", 8'h00, {7'h00, o_load.blk_wr});
    rchk(`ASF_OFF_STAT, 8'h8F, "block kept");
    pulse(1'b1);
    rchk(`ASF_OFF_STAT, 8'h0E, "done");
    chk("irq up", 8'h01, {7'h00, o_irq});
    rchk(`ASF_OFF_IRQ_STAT, 8'h03, "irq status");
    rchk(12'h000, 8'h00, "unmapped");
    chk("irq down", 8'h00, {7'h00, o_irq});
    $display("t_run done");
  endtask : t_run

  task automatic t_err;
    wr(`ASF_OFF_CTRL, 8'h01);
    wr(`ASF_OFF_STAT, 8'h80);
    rchk(`ASF_OFF_STAT, 8'h86, "restart");
    pulse(1'b0);
    pulse(1'b1);
    rchk(`ASF_OFF_STAT, 8'h0E, "proc error");
    rchk(`ASF_OFF_IRQ_STAT, 8'h01, "error only");
    $display("t_err done");
  endtask : t_err

  task automatic t_off;
    wr(`ASF_OFF_CTRL, 8'h00);
    rchk(`ASF_OFF_STAT, 8'h00, "off clears");
    wr(`ASF_OFF_CTRL, 8'h01);
    rchk(`ASF_OFF_STAT, 8'h00, "reenable");
    $display("t_off done");
  endtask : t_off

  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : finish_test

  initial begin
    repeat (5) @(posedge i_sys_clk);
    i_sys_rst <= 1'b0;
    t_reset();
    t_load();
    t_run();
    t_err();
    t_off();
    finish_test();
  end

  initial begin
    #5000;
    fail_count++;
    finish_test();
  end
endmodule : asf_status_flags_bench
